// File: logic/lcou_unit.sv
// Purpose: Logic complement and inclusive-OR slice of the core datapath
// Assumes: Decoder presents one operation per start pulse; memory answers
//          a read in the cycle after mem_rd
//          Only one request in flight; operands may change once taken
// Notes: Complement-with-carry runs as bit-field change with an all-ones
//        mask; OR-immediate runs as bit-field set with its immediate mask
//        Memory read data is taken one cycle after the read pulse, so the
//        near forms merge it in the finishing cycle itself
//        No saturation path exists here: logical results are raw patterns
//        A status destination of the bit-field forms takes its operand from the live flag bits
`timescale 1ns/1ns
`default_nettype none

module lcou_unit (
	input wire logic ref_clk, // Core clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic start, // One-cycle request from decoder
	input wire lcou_pkg::lcou_op_e op, // Operation
	input wire lcou_pkg::lcou_tgt_e tgt, // Target kind
	input wire logic [4:0] any_register_field, // Register code
	input wire logic [15:0] mask16, // Immediate mask for OR-immediate
	input wire logic [15:0] src_word, // Source word for register OR
	input wire logic [15:0] reg_value, // Current 16-bit register value
	input wire logic [35:0] acc_value, // Current accumulator value
	input wire logic [15:0] ea_addr, // Effective memory address
	input wire logic src_limited, // Limiting seen on 36-bit source move
	input wire logic limit_mode_bit, // Saturation mode (ignored here)
	input wire logic [7:0] condition_code_bits, // Current CC bits
	input wire logic [15:0] mem_rdata, // Memory read data
	output logic busy, // Operation in progress
	output logic done, // Last cycle pulse
	output logic illegal, // Rejected request pulse
	output logic [1:0] words_used, // Program words of last op
	output logic reg_we, // Register write pulse
	output logic [4:0] reg_wsel, // Register written
	output logic [15:0] reg_wdata, // Register write data
	output logic acc_we, // Accumulator write pulse
	output logic [35:0] acc_wdata, // Accumulator write data
	output logic mem_rd, // Memory read pulse
	output logic mem_we, // Memory write pulse
	output logic mem_io, // Access targets peripheral space
	output logic [15:0] mem_addr, // Memory address
	output logic [15:0] mem_wdata, // Memory write data
	output logic cc_we, // Condition code write pulse
	output logic [7:0] cc_out // New condition code bits
);
	import lcou_pkg::*;

	typedef enum logic [1:0] {
		LCOU_IDLE,
		LCOU_READ,
		LCOU_WAIT,
		LCOU_FINISH
	} lcou_state_e;

	typedef struct packed {
		// Sequencer
		lcou_state_e st;
		logic [2:0] cnt;
		// Request latched on the taking edge
		lcou_op_e op;
		lcou_tgt_e tgt;
		logic [15:0] mask;
		logic [15:0] operand;
		logic [35:0] acc;
		logic [4:0] rsel;
		logic lim;
		logic [7:0] cc_in;
		// Registered outputs
		logic busy;
		logic done;
		logic illegal;
		logic [1:0] words;
		logic reg_we;
		logic [15:0] reg_wdata;
		logic acc_we;
		logic [35:0] acc_wdata;
		logic mem_rd;
		logic rd_pend; // Read word is on the bus this cycle
		logic mem_we;
		logic mem_io;
		logic [15:0] mem_addr;
		logic [15:0] mem_wdata;
		logic cc_we;
		logic [7:0] cc;
	} lcou_s;

	lcou_s s_reg;
	lcou_s s_next;

	// -----------------------------------------------------------------
	// Helper functions
	// -----------------------------------------------------------------
	// Plain forms work on register and accumulator targets only; memory is refused for them
	function automatic logic lcou_plain_op(input lcou_op_e o);
		return (o == LCOU_OP_NOT || o == LCOU_OP_OR);
	endfunction

	// Targets reached through the data memory port
	function automatic logic lcou_mem_tgt(input lcou_tgt_e t);
		return (t != LCOU_TGT_ACC && t != LCOU_TGT_REG);
	endfunction

	// Status destination: a condition bit moves only where the mask is set,
	// so software can touch one flag without disturbing the others
	function automatic logic [7:0] lcou_merge_cc(input logic [7:0] cc,
		input logic [7:0] res, input logic [7:0] msk);
		return (cc & ~msk) | (res & msk);
	endfunction

	// Flag update for the plain forms; result word is bits 31..16 or reg
	function automatic logic [7:0] lcou_plain_cc(input logic [7:0] cc,
		input logic [15:0] res);
		logic [7:0] r;
		r = cc;
		r[CC_N] = res[WORD_W-1];
		r[CC_Z] = (res == 16'h0000);
		r[CC_V] = 1'b0;
		return r;
	endfunction

	// Cycle budget of a bit-field form by target kind
	function automatic logic [2:0] lcou_rmw_cycles(input lcou_tgt_e t);
		logic [2:0] c;
		c = CYC_RMW_NEAR;
		if (t == LCOU_TGT_PTR_OFS || t == LCOU_TGT_STACK_OFS ||
			t == LCOU_TGT_LONG_ABS) begin
			c = CYC_RMW_FAR;
		end
		return c;
	endfunction

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	// The limit mode input is deliberately never read: logical results are
	// raw bit patterns, so saturation would corrupt them.
	always_comb begin
		logic [15:0] res;
		logic [15:0] mask_eff;
		logic is_mem;
		logic [7:0] ncc;
		logic [15:0] opnd;
		res = 16'h0000;
		ncc = 8'h00;
		opnd = 16'h0000;
		s_next = s_reg;
		// Pulses default low; each state raises only what it drives
		s_next.done = 1'b0;
		s_next.illegal = 1'b0;
		s_next.reg_we = 1'b0;
		s_next.acc_we = 1'b0;
		s_next.mem_rd = 1'b0;
		s_next.mem_we = 1'b0;
		s_next.cc_we = 1'b0;
		is_mem = lcou_mem_tgt(s_reg.tgt);
		mask_eff = (s_reg.op == LCOU_OP_COMPLEMENT_WITH_CARRY_OP) ? ALL_ONES_MASK : s_reg.mask;
		// Memory answers one cycle after the read pulse; the word is taken
		// on that edge, since merging the bus any earlier would pick up
		// whatever stale value the memory was still showing
		s_next.rd_pend = s_reg.mem_rd;
		opnd = s_reg.operand;
		if (is_mem && s_reg.rd_pend) begin
			opnd = mem_rdata;
		end
		unique case (s_reg.st)
			LCOU_IDLE: begin
				// A request is taken only here; a start pulse while busy is
				// dropped, so the decoder must wait for done
				if (start) begin
					s_next.op = op;
					s_next.tgt = tgt;
					s_next.rsel = any_register_field;
					s_next.mask = (op == LCOU_OP_COMPLEMENT_WITH_CARRY_OP) ? ALL_ONES_MASK
						: mask16;
					s_next.operand = (tgt == LCOU_TGT_ACC)
						? acc_value[ACC_MID_HI:ACC_MID_LO] : reg_value;
					// Status destination works on the live condition bits
					if (tgt == LCOU_TGT_REG && !lcou_plain_op(op) &&
						any_register_field == REG_STATUS) begin
						s_next.operand = {8'h00, condition_code_bits};
					end
					s_next.acc = acc_value;
					s_next.lim = src_limited;
					s_next.cc_in = condition_code_bits;
					s_next.mem_io = (tgt == LCOU_TGT_SHORT_IO);
					// Short forms keep only a 6-bit address
					if (tgt == LCOU_TGT_SHORT_ABS || tgt == LCOU_TGT_SHORT_IO) begin
						s_next.mem_addr = {10'h000,
							ea_addr[SHORT_ADDR_W-1:0]};
					end else begin
						s_next.mem_addr = ea_addr;
					end
					// Refused requests pulse illegal and write nothing
					if (lcou_plain_op(op) && lcou_mem_tgt(tgt)) begin
						s_next.illegal = 1'b1;
					end else if ((op == LCOU_OP_COMPLEMENT_WITH_CARRY_OP || op == LCOU_OP_ORC) &&
						tgt == LCOU_TGT_REG &&
						any_register_field == REG_HARDWARE_STACK) begin
						s_next.illegal = 1'b1;
					end else begin
						// Accepted: count down from the form's cycle budget
						s_next.busy = 1'b1;
						if (lcou_plain_op(op)) begin
							// Plain forms skip the read phase entirely
							s_next.words = WORDS_ONE;
							s_next.cnt = CYC_SHORT - 3'h1;
							if (op == LCOU_OP_NOT) begin
								s_next.operand = ~s_next.operand;
							end else begin
								s_next.operand = s_next.operand
									| src_word;
							end
							s_next.st = LCOU_FINISH;
						end else begin
							s_next.words = (tgt == LCOU_TGT_LONG_ABS)
								? WORDS_THREE : WORDS_TWO;
							s_next.cnt = lcou_rmw_cycles(tgt) - 3'h1;
							s_next.st = LCOU_READ;
						end
					end
				end
			end
			LCOU_READ: begin
				// First destination access of the read-modify-write
				// Register and accumulator targets idle through the same
				// cycles, so each target kind keeps one fixed timing
				s_next.cnt = s_reg.cnt - 3'h1;
				if (is_mem) begin
					s_next.mem_rd = 1'b1;
				end
				s_next.st = LCOU_WAIT;
			end
			LCOU_WAIT: begin
				s_next.cnt = s_reg.cnt - 3'h1;
				// Keeps the read word once it has arrived
				s_next.operand = opnd;
				if (s_reg.cnt == 3'h2) begin
					s_next.st = LCOU_FINISH;
				end
			end
			LCOU_FINISH: begin
				// Single write-back cycle: result, flags and done together;
				// carry is judged on the operand before the change
				if (lcou_plain_op(s_reg.op)) begin
					// Only N, Z and V move; carry and limit are kept
					res = s_reg.operand;
					ncc = lcou_plain_cc(s_reg.cc_in, res);
				end else begin
					if (s_reg.op == LCOU_OP_COMPLEMENT_WITH_CARRY_OP) begin
						res = opnd ^ mask_eff;
					end else begin
						res = opnd | mask_eff;
					end
					ncc = s_reg.cc_in;
					if (s_reg.tgt == LCOU_TGT_REG && s_reg.rsel == REG_STATUS) begin
						// Status target: masked condition bits only
						ncc = lcou_merge_cc(s_reg.cc_in, res[CC_W-1:0],
							mask_eff[CC_W-1:0]);
					end else begin
						ncc[CC_L] = s_reg.lim;
						// Carry: all masked bits were set beforehand
						ncc[CC_C] = ((opnd & mask_eff)
							== mask_eff);
					end
				end
				s_next.cc = ncc;
				s_next.cc_we = 1'b1;
				if (s_reg.tgt == LCOU_TGT_ACC) begin
					s_next.acc_wdata = {s_reg.acc[ACC_W-1:ACC_MID_HI+1], res,
						s_reg.acc[ACC_MID_LO-1:0]};
					s_next.acc_we = 1'b1;
				end else if (s_reg.tgt == LCOU_TGT_REG) begin
					s_next.reg_wdata = res;
					s_next.reg_we = !(s_reg.rsel == REG_STATUS &&
						!lcou_plain_op(s_reg.op));
					if (s_reg.rsel == REG_STATUS && !s_next.reg_we) begin
						s_next.cc_we = 1'b1;
					end
				end else begin
					s_next.mem_wdata = res;
					s_next.mem_we = 1'b1;
				end
				s_next.done = 1'b1;
				s_next.busy = 1'b0;
				s_next.st = LCOU_IDLE;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	// Flops clear to zero; the condition copy starts from its reset pattern
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.cc <= CC_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// Outputs straight from the state flops; no logic sits after them,
	// so the decoder sees glitch-free pulses
	assign busy = s_reg.busy;
	assign done = s_reg.done;
	assign illegal = s_reg.illegal;
	assign words_used = s_reg.words;
	assign reg_we = s_reg.reg_we;
	assign reg_wsel = s_reg.rsel;
	assign reg_wdata = s_reg.reg_wdata;
	assign acc_we = s_reg.acc_we;
	assign acc_wdata = s_reg.acc_wdata;
	assign mem_rd = s_reg.mem_rd;
	assign mem_we = s_reg.mem_we;
	assign mem_io = s_reg.mem_io;
	assign mem_addr = s_reg.mem_addr;
	assign mem_wdata = s_reg.mem_wdata;
	assign cc_we = s_reg.cc_we;
	assign cc_out = s_reg.cc;
endmodule

`default_nettype wire

// File: logic/lcou_pkg.sv
// Purpose: Shared constants and types for the logic complement/OR unit
// Assumes: 16-bit data words, 36-bit accumulators
// Notes: Opcode and addressing encodings are local to this block
package lcou_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ACC_W = 36;
	localparam int unsigned ACC_MID_LO = 16;
	localparam int unsigned ACC_MID_HI = 31;
	localparam int unsigned SHORT_ADDR_W = 6;
	// Condition-code bit positions
	localparam int unsigned CC_C = 0;
	localparam int unsigned CC_V = 1;
	localparam int unsigned CC_Z = 2;
	localparam int unsigned CC_N = 3;
	localparam int unsigned CC_L = 6;
	localparam int unsigned CC_W = 8;
	localparam logic [7:0] CC_RESET = 8'h00;
	localparam logic [15:0] ALL_ONES_MASK = 16'hffff;
	// Cycle counts per form
	localparam logic [2:0] CYC_SHORT = 3'h2;
	localparam logic [2:0] CYC_RMW_NEAR = 3'h4;
	localparam logic [2:0] CYC_RMW_FAR = 3'h6;
	// Program words per form
	localparam logic [1:0] WORDS_ONE = 2'h1;
	localparam logic [1:0] WORDS_TWO = 2'h2;
	localparam logic [1:0] WORDS_THREE = 2'h3;
	// Register codes of the any_register_field
	localparam logic [4:0] REG_HARDWARE_STACK = 5'h1f;
	localparam logic [4:0] REG_STATUS = 5'h19;

	typedef enum logic [2:0] {
		LCOU_OP_NOT,
		LCOU_OP_OR,
		LCOU_OP_COMPLEMENT_WITH_CARRY_OP,
		LCOU_OP_ORC
	} lcou_op_e;

	// Target kinds
	typedef enum logic [2:0] {
		LCOU_TGT_ACC,
		LCOU_TGT_REG,
		LCOU_TGT_SHORT_ABS,
		LCOU_TGT_SHORT_IO,
		LCOU_TGT_PTR_OFS,
		LCOU_TGT_STACK_OFS,
		LCOU_TGT_LONG_ABS
	} lcou_tgt_e;
endpackage

// File: testbench/lcou_sva.sv
// Purpose: Timing and flag checks on the complement/OR unit
// Assumes: Operand inputs stay stable while an operation runs
// Notes: Bound to every lcou_unit instance
`timescale 1ns/1ns
`default_nettype none
module lcou_sva
	import lcou_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic rstn, // Reset, low
	input wire logic start, // Request
	input wire lcou_op_e op, // Operation
	input wire lcou_tgt_e tgt, // Target
	input wire logic [4:0] any_register_field, // Reg code
	input wire logic [35:0] acc_value, // Acc in
	input wire logic busy, // Busy
	input wire logic done, // Done
	input wire logic illegal, // Refused
	input wire logic reg_we, // Reg write
	input wire logic [15:0] reg_wdata, // Reg data
	input wire logic acc_we, // Acc write
	input wire logic [35:0] acc_wdata, // Acc data
	input wire logic mem_rd, // Mem read
	input wire logic mem_we, // Mem write
	input wire logic [15:0] mem_addr, // Mem address
	input wire logic cc_we, // CC write
	input wire logic [7:0] cc_out // CC out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic take;
	// A request only counts on an idle edge
	assign take = start && !busy;
	sequence s_plain;
		take && op inside {LCOU_OP_NOT, LCOU_OP_OR}
			&& tgt inside {LCOU_TGT_ACC, LCOU_TGT_REG};
	endsequence
	sequence s_near;
		take && op == LCOU_OP_ORC
			&& tgt inside {LCOU_TGT_SHORT_ABS, LCOU_TGT_SHORT_IO};
	endsequence
	sequence s_far;
		take && op == LCOU_OP_ORC && tgt inside {LCOU_TGT_PTR_OFS,
			LCOU_TGT_STACK_OFS, LCOU_TGT_LONG_ABS};
	endsequence
	a_plain_two: assert property (s_plain |-> ##2 done && cc_we)
		else $error("plain op not done in two cycles");
	a_ovf_clear: assert property (s_plain |-> ##2 !cc_out[CC_V])
		else $error("overflow not cleared");
	a_neg_flag: assert property (s_plain |-> ##2 cc_out[CC_N] ==
		(acc_we ? acc_wdata[31] : reg_wdata[15]))
		else $error("negative flag wrong");
	a_zero_flag: assert property (s_plain |-> ##2 cc_out[CC_Z] ==
		(acc_we ? acc_wdata[31:16] == 16'h0 : reg_wdata == 16'h0))
		else $error("zero flag wrong");
	a_acc_keep: assert property (take && op == LCOU_OP_NOT &&
		tgt == LCOU_TGT_ACC |-> ##2 acc_we
		&& acc_wdata[35:32] == $past(acc_value[35:32], 2)
		&& acc_wdata[15:0] == $past(acc_value[15:0], 2)
		&& acc_wdata[31:16] == ~$past(acc_value[31:16], 2))
		else $error("accumulator complement wrong");
	a_near_rmw: assert property (s_near |-> ##2 mem_rd
		&& mem_addr[15:6] == 10'h0 ##2 mem_we && done)
		else $error("near read-modify-write wrong");
	a_far_six: assert property (s_far |=> !done [*5] ##1 done)
		else $error("far op not done in six cycles");
	a_stack_refuse: assert property (take && tgt == LCOU_TGT_REG
		&& op inside {LCOU_OP_COMPLEMENT_WITH_CARRY_OP, LCOU_OP_ORC}
		&& any_register_field == REG_HARDWARE_STACK |=> illegal && !reg_we)
		else $error("stack register not refused");
endmodule
bind lcou_unit lcou_sva u_sva (.ref_clk(ref_clk), .rstn(rstn),
	.start(start), .op(op), .tgt(tgt),
	.any_register_field(any_register_field), .acc_value(acc_value),
	.busy(busy), .done(done), .illegal(illegal), .reg_we(reg_we),
	.reg_wdata(reg_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata),
	.mem_rd(mem_rd), .mem_we(mem_we), .mem_addr(mem_addr),
	.cc_we(cc_we), .cc_out(cc_out));
`default_nettype wire

// File: testbench/lcou_mem_model.sv
// Purpose: Data memory beside the unit
// Assumes: Only the low 6 address bits decode
// Notes: Long addresses alias onto the short ones
`timescale 1ns/1ns
`default_nettype none
module lcou_mem_model (
	input wire logic ref_clk, // Clock
	input wire logic mem_rd, // Read pulse
	input wire logic mem_we, // Write pulse
	input wire logic [15:0] mem_addr, // Address
	input wire logic [15:0] mem_wdata, // Write data
	output logic [15:0] mem_rdata // Read data
);
	logic [15:0] mem [64];
	initial begin
		foreach (mem[i]) mem[i] = 16'h00aa;
		mem_rdata = 16'h0000;
	end
	// Data valid one cycle after the pulse; toggles otherwise so no stale hit
	always @(posedge ref_clk) begin
		if (mem_we) mem[mem_addr[5:0]] <= mem_wdata;
		mem_rdata <= mem_rd ? mem[mem_addr[5:0]] : ~mem_rdata;
	end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: Directed tests of the complement/OR unit
// Assumes: One operation at a time, operands held meanwhile
// Notes: Memory model aliases long addresses onto the short range
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import lcou_pkg::*;
	logic ref_clk = 0, rstn = 0, start = 0, src_limited = 0;
	logic limit_mode_bit = 0;
	lcou_op_e op = LCOU_OP_NOT;
	lcou_tgt_e tgt = LCOU_TGT_ACC;
	logic [4:0] any_register_field = 5'h02;
	logic [15:0] mask16 = 0, src_word = 0, reg_value = 0, ea_addr = 0;
	logic [35:0] acc_value = 0;
	logic [7:0] condition_code_bits = 8'h00;
	logic busy, done, illegal, reg_we, acc_we, mem_rd, mem_we, mem_io, cc_we;
	logic [1:0] words_used;
	logic [4:0] reg_wsel;
	logic [15:0] reg_wdata, mem_addr, mem_wdata, mem_rdata;
	logic [35:0] acc_wdata;
	logic [7:0] cc_out;
	int miscompares = 0, checked = 0, cyc = 0, n;
	lcou_unit u_dut (.ref_clk(ref_clk), .rstn(rstn), .start(start),
		.op(op), .tgt(tgt), .any_register_field(any_register_field),
		.mask16(mask16), .src_word(src_word), .reg_value(reg_value),
		.acc_value(acc_value), .ea_addr(ea_addr),
		.src_limited(src_limited), .limit_mode_bit(limit_mode_bit),
		.condition_code_bits(condition_code_bits), .mem_rdata(mem_rdata),
		.busy(busy), .done(done), .illegal(illegal),
		.words_used(words_used), .reg_we(reg_we), .reg_wsel(reg_wsel),
		.reg_wdata(reg_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata),
		.mem_rd(mem_rd), .mem_we(mem_we), .mem_io(mem_io),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .cc_we(cc_we),
		.cc_out(cc_out));
	lcou_mem_model u_mem (.ref_clk(ref_clk), .mem_rd(mem_rd),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));
	initial forever #4 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [35:0] e, g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// Issue one request; n counts cycles from the taking edge to the answer
	task automatic run(input lcou_op_e o, input lcou_tgt_e t);
		@(posedge ref_clk);
		op <= o;
		tgt <= t;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		n = 1;
		#1;
		while (done !== 1'b1 && illegal !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, far above the roughly 70 cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		acc_value <= 36'h5_1234_5678;
		limit_mode_bit <= 1'b1;
		run(LCOU_OP_NOT, LCOU_TGT_ACC);
		chk("cycles", 2, n);
		chk("words", WORDS_ONE, words_used);
		chk("acc", 36'h5_edcb_5678, acc_wdata);
		chk("nzv", 3'b100, {cc_out[CC_N], cc_out[CC_Z], cc_out[CC_V]});
		$display("test complement done");
		run(LCOU_OP_OR, LCOU_TGT_REG);
		chk("reg", 16'h0000, reg_wdata);
		chk("rsel", 5'h02, reg_wsel);
		chk("nzv", 3'b010, {cc_out[CC_N], cc_out[CC_Z], cc_out[CC_V]});
		src_word <= 16'hff00;
		acc_value <= 36'h0_1234_5678;
		run(LCOU_OP_OR, LCOU_TGT_ACC);
		chk("acc", 36'h0_ff34_5678, acc_wdata);
		chk("n", 1, cc_out[CC_N]);
		$display("test or done");
		reg_value <= 16'hffff;
		run(LCOU_OP_COMPLEMENT_WITH_CARRY_OP, LCOU_TGT_REG);
		chk("cycles", 4, n);
		chk("words", WORDS_TWO, words_used);
		chk("reg", 16'h0000, reg_wdata);
		chk("c", 1, cc_out[CC_C]);
		any_register_field <= REG_HARDWARE_STACK;
		run(LCOU_OP_COMPLEMENT_WITH_CARRY_OP, LCOU_TGT_REG);
		chk("illegal", 1, illegal);
		chk("cycles", 1, n);
		$display("test carry complement done");
		any_register_field <= REG_STATUS;
		condition_code_bits <= 8'h5a;
		mask16 <= 16'h0003;
		run(LCOU_OP_ORC, LCOU_TGT_REG);
		chk("cc", 8'h5b, cc_out);
		chk("we", 2'b01, {reg_we, cc_we});
		run(LCOU_OP_COMPLEMENT_WITH_CARRY_OP, LCOU_TGT_REG);
		chk("cc", 8'ha5, cc_out);
		acc_value <= 36'h3_ffff_0000;
		run(LCOU_OP_COMPLEMENT_WITH_CARRY_OP, LCOU_TGT_ACC);
		chk("acc", 36'h3_0000_0000, acc_wdata);
		chk("c", 1, cc_out[CC_C]);
		$display("test status done");
		mask16 <= 16'h5050;
		ea_addr <= 16'h7c30;
		src_limited <= 1'b1;
		run(LCOU_OP_ORC, LCOU_TGT_SHORT_ABS);
		chk("cycles", 4, n);
		chk("addr", 16'h0030, mem_addr);
		chk("wdata", 16'h50fa, mem_wdata);
		chk("cl", 2'b01, {cc_out[CC_C], cc_out[CC_L]});
		mask16 <= 16'h0050;
		run(LCOU_OP_ORC, LCOU_TGT_LONG_ABS);
		chk("cycles", 6, n);
		chk("words", WORDS_THREE, words_used);
		chk("addr", 16'h7c30, mem_addr);
		chk("wdata", 16'h50fa, mem_wdata);
		chk("c", 1, cc_out[CC_C]);
		run(LCOU_OP_ORC, LCOU_TGT_PTR_OFS);
		chk("cycles", 6, n);
		mask16 <= 16'h0100;
		ea_addr <= 16'h1234;
		run(LCOU_OP_ORC, LCOU_TGT_SHORT_IO);
		chk("io", 1, mem_io);
		chk("addr", 16'h0034, mem_addr);
		chk("wdata", 16'h01aa, mem_wdata);
		chk("c", 0, cc_out[CC_C]);
		ea_addr <= 16'h0030;
		run(LCOU_OP_COMPLEMENT_WITH_CARRY_OP, LCOU_TGT_SHORT_ABS);
		chk("io", 0, mem_io);
		chk("wdata", 16'haf05, mem_wdata);
		chk("c", 0, cc_out[CC_C]);
		$display("test or immediate done");
		end_of_test();
	end
endmodule
`default_nettype wire
